// File: hw/sttt_down_chan.sv
module sttt_down_chan #(
	parameter int CNT_W = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic enable,
	input wire logic tick,
	input wire logic [CNT_W-1:0] load_value,
	output logic [CNT_W-1:0] count,
	output logic zero_pulse
);
	import sttt_pkg::*;

	logic [CNT_W-1:0] count_reg;
	logic zero_reg;
	logic live_reg;

	// first enabled edge only loads, so a zero left by reset never counts as expiry
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			live_reg <= 1'b0;
		end else begin
			live_reg <= enable;
		end
	end

	// R02 auto reloading counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= STTT_CNT_RESET[CNT_W-1:0];
		end else if (!enable) begin
			// disabled channel waits preloaded, so first period is full length
			count_reg <= load_value;
		end else if (!live_reg) begin
			count_reg <= load_value;
		end else if (tick) begin
			// R11 reload at zero
			if (count_reg == '0) begin
				count_reg <= load_value;
			end else begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end

	// R05 zero reached event
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			zero_reg <= 1'b0;
		end else begin
			zero_reg <= enable && live_reg && tick && (count_reg == '0);
		end
	end

	assign count = count_reg;
	assign zero_pulse = zero_reg;
endmodule : sttt_down_chan

// File: hw/sttt_pkg.sv
package sttt_pkg;
	// channel counts and widths
	localparam int STTT_PTT_CHANNELS = 5;
	localparam int STTT_PTT_SYS_CHANNELS = 4;
	localparam int STTT_PTT_XTAL_CHAN = 4;
	localparam int STTT_CNT_W = 32;
	localparam int STTT_PRESCALE_W = 8;
	localparam int STTT_TMT_CHANNELS = 4;

	// reset values
	localparam logic [31:0] STTT_CNT_RESET = 32'h0000_0000;
	localparam logic [7:0] STTT_PRESCALE_RESET = 8'h00;

	// power state of the surrounding system, gray coded along run, stop, wake
	typedef enum logic [1:0] {
		STTT_PWR_RUN = 2'b00,
		STTT_PWR_STOP = 2'b01,
		STTT_PWR_WAKE = 2'b11
	} sttt_power_t;
endpackage : sttt_pkg

// File: hw/sttt_top.sv
// Behaviour
// R01 - five tick timer channels, each independent with own counter and requests
// R02 - each tick channel has a 32-bit down counter that reloads automatically
// R03 - four channels count on system clock, one on crystal clock ticks
// R04 - crystal channel keeps counting in stop mode and requests clock restart
// R05 - at zero a channel optionally raises interrupt or converter trigger
// R06 - tick timer has no external pins, only on-chip request outputs
// R07 - task monitor has one 32-bit up counter behind an 8-bit prescaler
// R08 - task monitor has four 32-bit compare values against the shared counter
// R09 - each compare channel drives its own interrupt when counter reaches value
// R10 - task monitor counter can be halted in debug mode by configuration
// R11 - at zero a tick channel reloads its start value and keeps counting
module sttt_top #(
	parameter int CNT_W = sttt_pkg::STTT_CNT_W,
	parameter int PS_W = sttt_pkg::STTT_PRESCALE_W
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic stop_mode,
	input wire logic xtal_tick,
	input wire logic [sttt_pkg::STTT_PTT_CHANNELS-1:0] ptt_enable,
	input wire logic [sttt_pkg::STTT_PTT_CHANNELS*CNT_W-1:0] ptt_load_value,
	input wire logic [sttt_pkg::STTT_PTT_CHANNELS-1:0] ptt_irq_enable,
	input wire logic [sttt_pkg::STTT_PTT_CHANNELS-1:0] ptt_trig_enable,
	input wire logic [sttt_pkg::STTT_PTT_CHANNELS-1:0] ptt_irq_ack,
	output logic [sttt_pkg::STTT_PTT_CHANNELS*CNT_W-1:0] ptt_count,
	output logic [sttt_pkg::STTT_PTT_CHANNELS-1:0] ptt_irq,
	output logic [sttt_pkg::STTT_PTT_CHANNELS-1:0] ptt_trig,
	output logic wakeup_req,
	input wire logic tmt_enable,
	input wire logic [PS_W-1:0] tmt_prescale,
	input wire logic debug_mode,
	input wire logic tmt_debug_freeze,
	input wire logic [sttt_pkg::STTT_TMT_CHANNELS-1:0] tmt_cmp_enable,
	input wire logic [sttt_pkg::STTT_TMT_CHANNELS*CNT_W-1:0] tmt_cmp_value,
	input wire logic [sttt_pkg::STTT_TMT_CHANNELS-1:0] tmt_irq_ack,
	output logic [CNT_W-1:0] tmt_count,
	output logic [sttt_pkg::STTT_TMT_CHANNELS-1:0] tmt_irq
);
	import sttt_pkg::*;

	localparam int NP = STTT_PTT_CHANNELS;
	localparam int NT = STTT_TMT_CHANNELS;

	logic [NP-1:0] chan_tick;
	logic [NP-1:0] chan_zero;
	logic [NP-1:0] ptt_irq_reg;
	logic [NP-1:0] ptt_trig_reg;
	sttt_power_t pwr_reg;
	sttt_power_t pwr_next;
	logic wakeup_reg;

	// ---------------- periodic tick timer ----------------

	// R03 clock source per channel
	// R04 crystal channel ignores stop
	always_comb begin
		chan_tick = '0;
		for (int i = 0; i < NP; i++) begin
			if (i == STTT_PTT_XTAL_CHAN) begin
				chan_tick[i] = xtal_tick;
			end else begin
				// system clock is gated off in stop, so these channels freeze
				chan_tick[i] = !stop_mode;
			end
		end
	end

	// R01 five independent channels
	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_ptt
			sttt_down_chan #(
				.CNT_W(CNT_W)
			) u_chan (
				.clk(clk),
				.rstn(rstn),
				.enable(ptt_enable[g]),
				.tick(chan_tick[g]),
				.load_value(ptt_load_value[g*CNT_W +: CNT_W]),
				.count(ptt_count[g*CNT_W +: CNT_W]),
				.zero_pulse(chan_zero[g])
			);
		end
	endgenerate

	// R05 optional interrupt, set wins over ack
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptt_irq_reg <= '0;
		end else begin
			ptt_irq_reg <= (ptt_irq_reg & ~ptt_irq_ack) | (chan_zero & ptt_irq_enable);
		end
	end

	// R05 optional converter trigger
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ptt_trig_reg <= '0;
		end else begin
			ptt_trig_reg <= chan_zero & ptt_trig_enable;
		end
	end

	// R06 on-chip request outputs only
	assign ptt_irq = ptt_irq_reg;
	assign ptt_trig = ptt_trig_reg;

	// ---------------- stop mode wake-up ----------------

	always_comb begin
		pwr_next = pwr_reg;
		case (pwr_reg)
			STTT_PWR_RUN: begin
				if (stop_mode) begin
					pwr_next = STTT_PWR_STOP;
				end
			end
			STTT_PWR_STOP: begin
				// R04 time-out restarts clock
				if (!stop_mode) begin
					pwr_next = STTT_PWR_RUN;
				end else if (chan_zero[STTT_PTT_XTAL_CHAN]) begin
					pwr_next = STTT_PWR_WAKE;
				end
			end
			STTT_PWR_WAKE: begin
				// request held until the system has left stop
				if (!stop_mode) begin
					pwr_next = STTT_PWR_RUN;
				end
			end
			default: begin
				pwr_next = STTT_PWR_RUN;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwr_reg <= STTT_PWR_RUN;
		end else begin
			pwr_reg <= pwr_next;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wakeup_reg <= 1'b0;
		end else begin
			wakeup_reg <= (pwr_next == STTT_PWR_WAKE);
		end
	end

	assign wakeup_req = wakeup_reg;

	// ---------------- task monitor timer ----------------

	logic [PS_W-1:0] ps_reg;
	logic tmt_run;
	logic tmt_step;
	logic [CNT_W-1:0] tmt_cnt_reg;
	logic [CNT_W-1:0] tmt_cnt_next;
	logic [NT-1:0] tmt_hit;
	logic [NT-1:0] tmt_irq_reg;

	// R10 debug halt
	assign tmt_run = tmt_enable && !(debug_mode && tmt_debug_freeze);

	// R07 prescaler divides by value plus one
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ps_reg <= STTT_PRESCALE_RESET[PS_W-1:0];
		end else if (!tmt_enable) begin
			ps_reg <= '0;
		end else if (tmt_run) begin
			if (ps_reg >= tmt_prescale) begin
				ps_reg <= '0;
			end else begin
				ps_reg <= ps_reg + 1'b1;
			end
		end
	end

	assign tmt_step = tmt_run && (ps_reg >= tmt_prescale);
	assign tmt_cnt_next = tmt_cnt_reg + 1'b1;

	// R07 up counter, wraps freely
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmt_cnt_reg <= STTT_CNT_RESET[CNT_W-1:0];
		end else if (tmt_step) begin
			tmt_cnt_reg <= tmt_cnt_next;
		end
	end

	assign tmt_count = tmt_cnt_reg;

	// R08 compare per channel
	generate
		for (g = 0; g < NT; g++) begin : g_tmt
			// equality on the step avoids repeat hits while the count stands still
			assign tmt_hit[g] = tmt_step && tmt_cmp_enable[g]
				&& (tmt_cnt_next == tmt_cmp_value[g*CNT_W +: CNT_W]);
		end
	endgenerate

	// R09 own interrupt per channel
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tmt_irq_reg <= '0;
		end else begin
			tmt_irq_reg <= (tmt_irq_reg & ~tmt_irq_ack) | tmt_hit;
		end
	end

	assign tmt_irq = tmt_irq_reg;
endmodule : sttt_top

// File: verif/sttt_irq_sink.sv
module sttt_irq_sink #(
	parameter int N = 5
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic slow,
	input wire logic [N-1:0] irq,
	output logic [N-1:0] ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [N-1:0] age1_reg;
	logic [N-1:0] age2_reg;
	// slow mode: a busy controller leaves requests pending
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			age1_reg <= '0;
			age2_reg <= '0;
			ack <= '0;
		end else begin
			age1_reg <= irq;
			age2_reg <= age1_reg & irq;
			ack <= slow ? (age2_reg & irq) : irq;
		end
	end
endmodule : sttt_irq_sink

// File: verif/sttt_sva.sv
module sttt_chk #(
	parameter int CNT_W = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic stop_mode,
	input wire logic xtal_tick,
	input wire logic [4:0] ptt_enable,
	input wire logic [5*CNT_W-1:0] ptt_load_value,
	input wire logic [4:0] ptt_trig_enable,
	input wire logic [5*CNT_W-1:0] ptt_count,
	input wire logic [4:0] ptt_trig,
	input wire logic wakeup_req,
	input wire logic debug_mode,
	input wire logic tmt_debug_freeze,
	input wire logic [4*CNT_W-1:0] tmt_cmp_value,
	input wire logic [CNT_W-1:0] tmt_count,
	input wire logic [3:0] tmt_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	wire [CNT_W-1:0] c0 = ptt_count[CNT_W-1:0];
	wire [CNT_W-1:0] c1 = ptt_count[2*CNT_W-1:CNT_W];
	wire [CNT_W-1:0] c4 = ptt_count[5*CNT_W-1:4*CNT_W];
	wire [CNT_W-1:0] l0 = ptt_load_value[CNT_W-1:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// first enabled edge excluded: start-up load is not a count step
	sequence run0;
		ptt_enable[0] && $past(ptt_enable[0]) && !stop_mode;
	endsequence
	reload_zero_a: assert property (run0 ##0 c0 == '0 |=> c0 == $past(l0))
		else $error("no reload");
	count_down_a: assert property (run0 ##0 c0 != '0 |=> c0 == $past(c0) - 1)
		else $error("no decrement");
	stop_hold_a: assert property (ptt_enable[1] && $past(ptt_enable[1]) && stop_mode |=> $stable(c1))
		else $error("counted in stop");
	xtal_hold_a: assert property (ptt_enable[4] && $past(ptt_enable[4]) && !xtal_tick |=> $stable(c4))
		else $error("crystal channel moved");
	sequence xtal_expire;
		stop_mode && ptt_enable[4] && $past(ptt_enable[4]) && xtal_tick && c4 == '0;
	endsequence
	wake_set_a: assert property (xtal_expire ##1 stop_mode |=> wakeup_req)
		else $error("no wakeup");
	trig_cause_a: assert property (ptt_trig[0] |-> $past(ptt_trig_enable[0]) && $past(c0) == $past(l0))
		else $error("stray trigger");
	tmt_freeze_a: assert property (debug_mode && tmt_debug_freeze |=> $stable(tmt_count))
		else $error("counted in freeze");
	tmt_irq_a: assert property ($rose(tmt_irq[0]) |-> tmt_count == tmt_cmp_value[CNT_W-1:0])
		else $error("compare irq off value");
endmodule : sttt_chk
bind sttt_top sttt_chk #(.CNT_W(CNT_W)) chk (.*);

// File: verif/sttt_tb_top.sv
module sttt_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, stop_mode = 0, xtal_tick = 0, slow = 0;
	logic tmt_enable = 0, debug_mode = 0, tmt_debug_freeze = 0, wakeup_req;
	logic [4:0] ptt_enable = 0, ptt_irq_enable = 0, ptt_trig_enable = 0;
	logic [4:0] ptt_irq_ack, ptt_irq, ptt_trig;
	logic [159:0] ptt_load_value = 0, ptt_count;
	logic [7:0] tmt_prescale = 0;
	logic [3:0] tmt_cmp_enable = 0, tmt_irq_ack, tmt_irq;
	logic [127:0] tmt_cmp_value = 0;
	logic [31:0] tmt_count, snap;
	int seed = 36, n_errors = 0, n_compared = 0, xt = 0, k, i;
	sttt_top uut (.*);
	sttt_irq_sink #(.N(5)) ptt_sink (.clk(clk), .rstn(rstn), .slow(slow), .irq(ptt_irq),
		.ack(ptt_irq_ack));
	sttt_irq_sink #(.N(4)) tmt_sink (.clk(clk), .rstn(rstn), .slow(slow), .irq(tmt_irq),
		.ack(tmt_irq_ack));
	initial forever #25 clk = ~clk;
	// crystal at a quarter of the system clock
	always @(posedge clk) begin
		xt <= (xt + 1) % 4;
		xtal_tick <= xt == 2;
	end
	function automatic int tick_period(input logic [31:0] load, input int div);
		return (load + 1) * div;
	endfunction : tick_period
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task automatic wt(input int sel, input int ch);
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			if ((sel == 0 ? ptt_trig[ch] : sel == 1 ? wakeup_req : tmt_irq[ch]) === 1'b1) return;
		end
		n_errors++;
		complete_run();
	endtask : wt
	task automatic period(input int ch, input int exp);
		int n;
		wt(0, ch);
		check(ptt_irq[ch], ptt_irq_enable[ch]);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ptt_trig[ch] !== 1'b1 && n < 300);
		check(n, exp);
	endtask : period
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		// ch3 gets the shortest period
		for (k = 0; k < 5; k++) ptt_load_value[k*32+:32] <= k == 3 ? 1 : 3 + ($random(seed) & 7);
		ptt_irq_enable <= $random(seed);
		ptt_trig_enable <= 5'h1F;
		repeat (2) @(posedge clk);
		ptt_enable <= 5'h1F;
		for (i = 0; i < 2; i++) begin
			@(posedge clk);
			slow <= i;
			for (k = 0; k < 5; k++) period(k, tick_period(ptt_load_value[k*32+:32], k == 4 ? 4 : 1));
		end
		@(posedge clk);
		stop_mode <= 1;
		@(negedge clk);
		snap = ptt_count[63:32];
		wt(1, 0);
		check(ptt_count[63:32], snap);
		@(posedge clk);
		stop_mode <= 0;
		repeat (2) @(negedge clk);
		check(wakeup_req, 1'b0);
		@(posedge clk);
		tmt_prescale <= 1;
		for (k = 0; k < 4; k++) tmt_cmp_value[k*32+:32] <= 4 + 3 * k + ($random(seed) & 1);
		tmt_cmp_enable <= 4'hF;
		tmt_enable <= 1;
		for (k = 0; k < 4; k++) begin
			wt(2, k);
			check(tmt_count, tmt_cmp_value[k*32+:32]);
			@(negedge clk);
			check(tmt_count, tmt_cmp_value[k*32+:32]);
			@(negedge clk);
			check(tmt_count, tmt_cmp_value[k*32+:32] + 1);
		end
		@(posedge clk);
		debug_mode <= 1;
		tmt_debug_freeze <= 1;
		@(negedge clk);
		snap = tmt_count;
		repeat (6) @(negedge clk);
		check(tmt_count, snap);
		@(posedge clk);
		tmt_debug_freeze <= 0;
		repeat (6) @(negedge clk);
		check(tmt_count, snap + 3);
		complete_run();
	end
endmodule : sttt_tb_top
